// ---- pkg/twc_pkg.sv ----
// Contract
// - nonzero action field overrides pin, direction enables driver
// - non-pwm A: off, toggle, clear, set
// - fast pwm A: toggle needs high bit, clear/set bottom
// - fast pwm A at top: match ignored, bottom acts
// - phase pwm A: up/down match actions, toggle needs high
// - phase pwm at top: match ignored, act at top
// - non-pwm B: off, toggle, clear, set
// - fast pwm B: 01 reserved, clear/set bottom
// - phase pwm B: 01 reserved, up/down match actions
// - mode field split over both registers; 4,6 reserved
// - pwm modes top, buffer update and overflow point
// - force strobe applies immediate match action
// - force strobes work only in non-pwm modes
// - forced match: no flag, no counter clear
// - force strobes always read as zero
// - clock select: stop, direct, prescaled divisions
// - async select clocks from crystal pin
// - prescaler reset bit clears prescaler
// - compare registers continuously matched against counter
`default_nettype none
package twc_pkg;
	localparam logic [7:0] TWC_OFS_CTRL_A = 8'hB0;
	localparam logic [7:0] TWC_OFS_CTRL_B = 8'hB1;
	localparam logic [7:0] TWC_OFS_CNT    = 8'hB2;
	localparam logic [7:0] TWC_OFS_CMP_A  = 8'hB3;
	localparam logic [7:0] TWC_OFS_CMP_B  = 8'hB4;
	localparam logic [7:0] TWC_OFS_ASYNC  = 8'hB6;
	localparam logic [7:0] TWC_OFS_PSR    = 8'hB7;
	localparam int TWC_COM_A_LSB  = 6;
	localparam int TWC_COM_B_LSB  = 4;
	localparam int TWC_WGM_LO_LSB = 0;
	localparam int TWC_FOC_A_BIT  = 7;
	localparam int TWC_FOC_B_BIT  = 6;
	localparam int TWC_WGM_HI_BIT = 3;
	localparam int TWC_CS_LSB     = 0;
	localparam int TWC_ASYNC_BIT  = 5;
	localparam int TWC_PSR_BIT    = 0;
	localparam logic [7:0] TWC_CTRL_A_MASK = 8'hF3;
	localparam logic [7:0] TWC_CTRL_B_MASK = 8'h0F;
	localparam logic [7:0] TWC_RST_BYTE    = 8'h00;
	localparam logic [7:0] TWC_MAX         = 8'hFF;
	localparam logic [7:0] TWC_BOTTOM      = 8'h00;
	localparam logic [1:0] TWC_COM_OFF     = 2'h0;
	localparam logic [1:0] TWC_COM_TOGGLE  = 2'h1;
	localparam logic [1:0] TWC_COM_CLEAR   = 2'h2;
	localparam logic [1:0] TWC_COM_SET     = 2'h3;
	localparam int TWC_PRESC_W = 10;

	typedef enum logic [2:0] {
		MODE_NORMAL   = 3'h0,
		MODE_PC_MAX   = 3'h1,
		MODE_CTC      = 3'h2,
		MODE_FAST_MAX = 3'h3,
		MODE_RSV4     = 3'h4,
		MODE_PC_CMP   = 3'h5,
		MODE_RSV6     = 3'h6,
		MODE_FAST_CMP = 3'h7
	} twc_mode_e;

	typedef enum logic [2:0] {
		CS_STOP = 3'h0,
		CS_DIV1 = 3'h1,
		CS_DIV8 = 3'h2,
		CS_DIV32 = 3'h3,
		CS_DIV64 = 3'h4,
		CS_DIV128 = 3'h5,
		CS_DIV256 = 3'h6,
		CS_DIV1024 = 3'h7
	} twc_cs_e;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} twc_bus_req_s;

	typedef struct packed {
		logic wave;
		logic ovr;
		logic oe;
	} twc_pin_s;

	typedef struct packed {
		logic ovf;
		logic match_a;
		logic match_b;
	} twc_evt_s;
endpackage
`default_nettype wire

// ---- hdl/twc_top.sv ----
// The plain strobed port was left to the implementer.
`default_nettype none
module twc_top (
	// clock and reset
	input  wire logic                  mclk,
	input  wire logic                  resetn,
	// register port
	input  wire twc_pkg::twc_bus_req_s bus_req,
	output var  logic [7:0]            rdata,
	// pin direction bits and crystal clock
	input  wire logic                  dir_a,
	input  wire logic                  dir_b,
	input  wire logic                  crystal_clock_pin,
	// waveform pins and events
	output var  twc_pkg::twc_pin_s     wave_out_a,
	output var  twc_pkg::twc_pin_s     wave_out_b,
	output var  twc_pkg::twc_evt_s     evt
);
	import twc_pkg::*;

	typedef struct packed {
		logic [7:0]             ctrl_a;
		logic [7:0]             ctrl_b;
		logic [7:0]             cnt;
		logic [7:0]             cmp_a_buf;
		logic [7:0]             cmp_b_buf;
		logic [7:0]             cmp_a;
		logic [7:0]             cmp_b;
		logic                   down;
		logic                   blk;
		logic [TWC_PRESC_W-1:0] presc;
		logic                   xtal_prev;
		logic                   async_sel;
		logic [7:0]             rdata;
		twc_pin_s               pin_a;
		twc_pin_s               pin_b;
		twc_evt_s               evt;
	} twc_state_s;

	twc_state_s s_ff;
	twc_state_s nxt_s;

	function automatic logic is_pwm(input logic [2:0] m);
		is_pwm = m[0];
	endfunction

	function automatic logic is_rsv(input logic [2:0] m);
		is_rsv = (m == MODE_RSV4) || (m == MODE_RSV6);
	endfunction

	// pin override decision, shared by both channels
	function automatic logic connected(
		input logic [1:0] com,
		input logic [2:0] m,
		input logic       is_b
	);
		connected = (com != TWC_COM_OFF);
		if (is_rsv(m))
			connected = 1'b0;
		else if (is_pwm(m) && com == TWC_COM_TOGGLE)
			connected = !is_b && m[2];
	endfunction

	// next waveform level for one channel
	function automatic logic wave_next(
		input logic       cur,
		input logic [1:0] com,
		input logic [2:0] m,
		input logic       is_b,
		input logic       match,
		input logic       force_m,
		input logic       bottom,
		input logic       top_pc,
		input logic       up,
		input logic       cmp_top
	);
		logic r;
		r = cur;
		if (is_rsv(m)) begin
			r = cur;
		end else if (!is_pwm(m)) begin
			if (match || force_m) begin
				case (com)
					TWC_COM_TOGGLE: r = ~cur;
					TWC_COM_CLEAR:  r = 1'b0;
					TWC_COM_SET:    r = 1'b1;
					default:        r = cur;
				endcase
			end
		end else if (com == TWC_COM_TOGGLE) begin
			if (!is_b && m[2] && match)
				r = ~cur;
		end else if (com[1] && m[1]) begin
			if (match && !cmp_top)
				r = com[0];
			if (bottom)
				r = ~com[0];
		end else if (com[1]) begin
			if (match && !cmp_top)
				r = up ? com[0] : ~com[0];
			if (top_pc && cmp_top)
				r = com[0];
		end
		wave_next = r;
	endfunction

	// prescaler tap for the selected division
	function automatic logic presc_tap(
		input logic [2:0]             cs,
		input logic [TWC_PRESC_W-1:0] p
	);
		case (cs)
			CS_DIV1:    presc_tap = 1'b1;
			CS_DIV8:    presc_tap = &p[2:0];
			CS_DIV32:   presc_tap = &p[4:0];
			CS_DIV64:   presc_tap = &p[5:0];
			CS_DIV128:  presc_tap = &p[6:0];
			CS_DIV256:  presc_tap = &p[7:0];
			CS_DIV1024: presc_tap = &p[9:0];
			default:    presc_tap = 1'b0;
		endcase
	endfunction

	logic [2:0] mode;
	logic [1:0] com_a;
	logic [1:0] com_b;
	logic [7:0] top;
	logic       src_tick;
	logic       tick;
	logic       at_top;
	logic       wrap;
	logic       pc_top;
	logic       pc_bottom;
	logic       match_a;
	logic       match_b;
	logic       force_a;
	logic       force_b;
	logic       wr_b;

	always_comb begin
		nxt_s = s_ff;
		mode = {s_ff.ctrl_b[TWC_WGM_HI_BIT],
			s_ff.ctrl_a[TWC_WGM_LO_LSB+1:TWC_WGM_LO_LSB]};
		com_a = s_ff.ctrl_a[TWC_COM_A_LSB+1:TWC_COM_A_LSB];
		com_b = s_ff.ctrl_a[TWC_COM_B_LSB+1:TWC_COM_B_LSB];
		// top is the compare A value in ctc and modes 5 and 7
		top = (mode == MODE_CTC || mode == MODE_PC_CMP || mode == MODE_FAST_CMP)
			? s_ff.cmp_a : TWC_MAX;
		// crystal pin is only edge sampled, so it must be well below mclk
		src_tick = s_ff.async_sel ? (crystal_clock_pin && !s_ff.xtal_prev)
			: 1'b1;
		tick = src_tick && presc_tap(s_ff.ctrl_b[TWC_CS_LSB+2:TWC_CS_LSB],
			s_ff.presc);
		at_top = (s_ff.cnt == top);
		wrap = tick && at_top && mode[1];
		pc_top = tick && is_pwm(mode) && !mode[1] && !s_ff.down && at_top;
		pc_bottom = tick && is_pwm(mode) && !mode[1] && s_ff.down
			&& (s_ff.cnt == TWC_BOTTOM);
		match_a = tick && !s_ff.blk && (s_ff.cnt == s_ff.cmp_a);
		match_b = tick && !s_ff.blk && (s_ff.cnt == s_ff.cmp_b);
		wr_b = bus_req.wr && bus_req.addr == TWC_OFS_CTRL_B;
		force_a = wr_b && bus_req.wdata[TWC_FOC_A_BIT] && !is_pwm(mode);
		force_b = wr_b && bus_req.wdata[TWC_FOC_B_BIT] && !is_pwm(mode);

		nxt_s.xtal_prev = crystal_clock_pin;
		if (src_tick)
			nxt_s.presc = s_ff.presc + 1'b1;

		// counter sequence per mode
		if (tick) begin
			nxt_s.blk = 1'b0;
			if (is_pwm(mode) && !mode[1]) begin
				if (pc_top) begin
					nxt_s.down = 1'b1;
					nxt_s.cnt = s_ff.cnt - 8'h01;
				end else if (pc_bottom) begin
					nxt_s.down = 1'b0;
					nxt_s.cnt = s_ff.cnt + 8'h01;
				end else begin
					nxt_s.cnt = s_ff.down ? s_ff.cnt - 8'h01 : s_ff.cnt + 8'h01;
				end
			end else if (mode == MODE_FAST_MAX || mode == MODE_FAST_CMP) begin
				nxt_s.cnt = at_top ? TWC_BOTTOM : s_ff.cnt + 8'h01;
			end else begin
				// ctc clears when the count reaches top, even with the match blocked, never on a forced one
				nxt_s.cnt = (mode == MODE_CTC && at_top) ? TWC_BOTTOM
					: s_ff.cnt + 8'h01;
			end
		end

		// compare buffer update point
		if (!is_pwm(mode)) begin
			nxt_s.cmp_a = s_ff.cmp_a_buf;
			nxt_s.cmp_b = s_ff.cmp_b_buf;
		end else if ((mode[1] && tick && at_top) || pc_top) begin
			nxt_s.cmp_a = s_ff.cmp_a_buf;
			nxt_s.cmp_b = s_ff.cmp_b_buf;
		end

		// overflow event point
		nxt_s.evt.ovf = 1'b0;
		if (!is_rsv(mode)) begin
			if (mode == MODE_FAST_CMP)
				nxt_s.evt.ovf = tick && at_top;
			else if (is_pwm(mode) && !mode[1])
				nxt_s.evt.ovf = pc_bottom;
			else
				nxt_s.evt.ovf = tick && (s_ff.cnt == TWC_MAX);
		end
		// flags only from real matches
		nxt_s.evt.match_a = match_a;
		nxt_s.evt.match_b = match_b;

		nxt_s.pin_a.wave = wave_next(s_ff.pin_a.wave, com_a, mode, 1'b0,
			match_a, force_a, wrap, pc_top, !s_ff.down,
			s_ff.cmp_a == top);
		nxt_s.pin_b.wave = wave_next(s_ff.pin_b.wave, com_b, mode, 1'b1,
			match_b, force_b, wrap, pc_top, !s_ff.down,
			s_ff.cmp_b == top);
		nxt_s.pin_a.ovr = connected(com_a, mode, 1'b0);
		nxt_s.pin_b.ovr = connected(com_b, mode, 1'b1);
		nxt_s.pin_a.oe = connected(com_a, mode, 1'b0) && dir_a;
		nxt_s.pin_b.oe = connected(com_b, mode, 1'b1) && dir_b;

		// register writes
		if (bus_req.wr) begin
			case (bus_req.addr)
				TWC_OFS_CTRL_A: nxt_s.ctrl_a = bus_req.wdata & TWC_CTRL_A_MASK;
				// force bits are strobes and are never stored
				TWC_OFS_CTRL_B: nxt_s.ctrl_b = bus_req.wdata & TWC_CTRL_B_MASK;
				TWC_OFS_CNT: begin
					nxt_s.cnt = bus_req.wdata;
					nxt_s.blk = 1'b1;
				end
				TWC_OFS_CMP_A: nxt_s.cmp_a_buf = bus_req.wdata;
				TWC_OFS_CMP_B: nxt_s.cmp_b_buf = bus_req.wdata;
				TWC_OFS_ASYNC: nxt_s.async_sel = bus_req.wdata[TWC_ASYNC_BIT];
				TWC_OFS_PSR: begin
					if (bus_req.wdata[TWC_PSR_BIT])
						nxt_s.presc = '0;
				end
				default: nxt_s.blk = s_ff.blk;
			endcase
		end

		// register reads, unmapped addresses read zero
		nxt_s.rdata = TWC_RST_BYTE;
		if (bus_req.rd) begin
			case (bus_req.addr)
				TWC_OFS_CTRL_A: nxt_s.rdata = s_ff.ctrl_a;
				TWC_OFS_CTRL_B: nxt_s.rdata = s_ff.ctrl_b;
				TWC_OFS_CNT:    nxt_s.rdata = s_ff.cnt;
				TWC_OFS_CMP_A:  nxt_s.rdata = s_ff.cmp_a_buf;
				TWC_OFS_CMP_B:  nxt_s.rdata = s_ff.cmp_b_buf;
				TWC_OFS_ASYNC:  nxt_s.rdata[TWC_ASYNC_BIT] = s_ff.async_sel;
				default:        nxt_s.rdata = TWC_RST_BYTE;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (!resetn)
			s_ff <= '0;
		else
			s_ff <= nxt_s;
	end

	assign rdata = s_ff.rdata;
	assign wave_out_a = s_ff.pin_a;
	assign wave_out_b = s_ff.pin_b;
	assign evt = s_ff.evt;
endmodule
`default_nettype wire

// ---- testbench/twc_sva.sv ----
`default_nettype none
module twc_sva (
	// clock and reset
	input wire logic                  mclk,
	input wire logic                  resetn,
	// register port
	input wire twc_pkg::twc_bus_req_s bus_req,
	input wire logic [7:0]            rdata,
	// pins and events
	input wire logic                  dir_a,
	input wire twc_pkg::twc_pin_s     wave_out_a,
	input wire twc_pkg::twc_pin_s     wave_out_b,
	input wire twc_pkg::twc_evt_s     evt
);
	import twc_pkg::*;
	logic [7:0] sh_a_ff;
	logic [7:0] sh_b_ff;
	logic       wa;
	logic       wb;
	logic       fz;
	assign wa = bus_req.wr && bus_req.addr == TWC_OFS_CTRL_A;
	assign wb = bus_req.wr && bus_req.addr == TWC_OFS_CTRL_B;
	// stopped counter, plain mode before and after the write: a reserved mode swallows it
	assign fz = wb && !bus_req.wdata[3] && !sh_b_ff[3] && !sh_a_ff[0]
		&& sh_b_ff[2:0] == 3'h0;
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			sh_a_ff <= 8'h00;
			sh_b_ff <= 8'h00;
		end else begin
			if (wa) sh_a_ff <= bus_req.wdata;
			if (wb) sh_b_ff <= bus_req.wdata;
		end
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);
	property p_oe_a;
		$stable(wave_out_a.ovr) |-> wave_out_a.oe == (wave_out_a.ovr && $past(dir_a));
	endproperty
	a_oe_a: assert property (p_oe_a) else $error("oe a wrong");
	property p_oe_b;
		wave_out_b.oe |-> wave_out_b.ovr;
	endproperty
	a_oe_b: assert property (p_oe_b) else $error("oe b without ovr");
	property p_off_a;
		wa && bus_req.wdata[7:6] == 2'h0 |-> ##[1:2] !wave_out_a.ovr;
	endproperty
	a_off_a: assert property (p_off_a) else $error("a still connected");
	property p_fset_a;
		fz && bus_req.wdata[7] && sh_a_ff[7:6] == 2'h3 |=> wave_out_a.wave;
	endproperty
	a_fset_a: assert property (p_fset_a) else $error("force set a");
	property p_ftog_a;
		fz && bus_req.wdata[7] && sh_a_ff[7:6] == 2'h1 |=>
			wave_out_a.wave != $past(wave_out_a.wave);
	endproperty
	a_ftog_a: assert property (p_ftog_a) else $error("force toggle a");
	property p_fclr_b;
		fz && bus_req.wdata[6] && sh_a_ff[5:4] == 2'h2 |=> !wave_out_b.wave;
	endproperty
	a_fclr_b: assert property (p_fclr_b) else $error("force clear b");
	property p_fpwm_a;
		wb && sh_a_ff[0] && sh_b_ff[2:0] == 3'h0 |=> $stable(wave_out_a.wave);
	endproperty
	a_fpwm_a: assert property (p_fpwm_a) else $error("pwm wave moved");
	property p_fevt;
		fz && bus_req.wdata[7:6] != 2'h0 |=> !evt.match_a && !evt.match_b;
	endproperty
	a_fevt: assert property (p_fevt) else $error("force gave event");
	property p_rd_b;
		bus_req.rd && bus_req.addr == TWC_OFS_CTRL_B |=> rdata == (sh_b_ff & TWC_CTRL_B_MASK);
	endproperty
	a_rd_b: assert property (p_rd_b) else $error("ctrl b read");
	property p_rd_a;
		bus_req.rd && bus_req.addr == TWC_OFS_CTRL_A |=> rdata == (sh_a_ff & TWC_CTRL_A_MASK);
	endproperty
	a_rd_a: assert property (p_rd_a) else $error("ctrl a read");
endmodule
bind twc_top twc_sva twc_sva_i (.mclk(mclk), .resetn(resetn), .bus_req(bus_req),
	.rdata(rdata), .dir_a(dir_a), .wave_out_a(wave_out_a), .wave_out_b(wave_out_b),
	.evt(evt));
`default_nettype wire

// ---- testbench/twc_pin_load.sv ----
`default_nettype none
module twc_pin_load (
	// pins from the block
	input  wire twc_pkg::twc_pin_s wave_out_a,
	input  wire twc_pkg::twc_pin_s wave_out_b,
	// pad levels
	output var  logic              pin_a,
	output var  logic              pin_b
);
	import twc_pkg::*;
	// undriven pad rests on its pull-up, never the last driven level
	assign pin_a = wave_out_a.oe ? wave_out_a.wave : 1'b1;
	assign pin_b = wave_out_b.oe ? wave_out_b.wave : 1'b1;
endmodule
`default_nettype wire

// ---- testbench/twc_tb_top.sv ----
`default_nettype none
module twc_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import twc_pkg::*;
	logic         mclk = 1'b0;
	logic         resetn = 1'b0;
	logic         dir_a = 1'b0;
	logic         dir_b = 1'b0;
	logic         xtal = 1'b0;
	twc_bus_req_s bus_req = '0;
	logic [7:0]   rdata;
	twc_pin_s     wa;
	twc_pin_s     wb;
	twc_evt_s     evt;
	logic         pin_a;
	logic         pin_b;
	int           bad_count = 0;
	int           compares = 0;
	always #5 mclk = ~mclk;
	// slow crystal, eight system cycles a period
	always begin
		repeat (4) @(posedge mclk);
		xtal <= ~xtal;
	end
	twc_top twc_top_i (.mclk(mclk), .resetn(resetn), .bus_req(bus_req), .rdata(rdata),
		.dir_a(dir_a), .dir_b(dir_b), .crystal_clock_pin(xtal), .wave_out_a(wa),
		.wave_out_b(wb), .evt(evt));
	twc_pin_load twc_pin_load_i (.wave_out_a(wa), .wave_out_b(wb), .pin_a(pin_a),
		.pin_b(pin_b));
	task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(logic [7:0] a, logic [7:0] d);
		@(posedge mclk);
		bus_req <= '{a, d, 1'b1, 1'b0};
		@(posedge mclk);
		bus_req <= '0;
	endtask
	task automatic rd(logic [7:0] a, output logic [7:0] d);
		@(posedge mclk);
		bus_req <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge mclk);
		bus_req <= '0;
		#1 d = rdata;
	endtask
	// cycles up to the next pulse, bounded so a dead counter cannot hang
	task automatic gap(bit o, output int n);
		n = 0;
		do begin
			@(posedge mclk);
			#1 n++;
		end while ((o ? evt.ovf : evt.match_a) !== 1'b1 && n < 9000);
	endtask
	function automatic logic exp_ovr(logic [1:0] c, logic [2:0] m, logic b);
		if (c == 2'h0 || m == 3'h4 || m == 3'h6)
			return 1'b0;
		if (c == 2'h1 && m[0])
			return m[2] && !b;
		return 1'b1;
	endfunction
	task automatic print_verdict();
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		repeat (60000) @(posedge mclk);
		bad_count++;
		print_verdict();
	end
	initial begin
		logic [7:0] a;
		logic [7:0] b;
		logic [7:0] d;
		logic [2:0] m;
		int         n;
		logic       pb3;
		logic       w0a;
		logic       w0b;
		int         dv[8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
		logic [2:0] mv[5] = '{3'h0, 3'h3, 3'h7, 3'h1, 3'h5};
		int         ev[5] = '{256, 256, 4, 510, 6};
		void'($urandom(65));
		repeat (16) @(posedge mclk);
		resetn <= 1'b1;
		rd(TWC_OFS_CTRL_A, d);
		chk("rst_a", d, TWC_RST_BYTE);
		rd(TWC_OFS_CTRL_B, d);
		chk("rst_b", d, TWC_RST_BYTE);
		pb3 = 1'b0;
		for (int i = 0; i < 48; i++) begin
			a = 8'($urandom);
			b = 8'($urandom) & 8'hC8;
			if (i < 8) begin
				a[1:0] = i[1:0];
				b[3] = i[2];
			end
			m = {b[3], a[1:0]};
			if (m[0]) b[7:6] = 2'h0;
			@(posedge mclk);
			dir_a <= a[2];
			dir_b <= a[3];
			wr(TWC_OFS_CTRL_A, a);
			#1;
			w0a = wa.wave;
			w0b = wb.wave;
			wr(TWC_OFS_CTRL_B, b);
			repeat (2) @(posedge mclk);
			#1;
			chk("ovr_a", wa.ovr, exp_ovr(a[7:6], m, 1'b0));
			chk("ovr_b", wb.ovr, exp_ovr(a[5:4], m, 1'b1));
			chk("oe_b", wb.oe, exp_ovr(a[5:4], m, 1'b1) & a[3]);
			if (!exp_ovr(a[7:6], m, 1'b0) || !a[2]) chk("pin_a", pin_a, 1'b1);
			if (!exp_ovr(a[5:4], m, 1'b1) || !a[3]) chk("pin_b", pin_b, 1'b1);
			// force is judged in the mode before the write; reserved there means no action
			if (b[7] && m inside {3'h0, 3'h2} && a[7]) chk("fa", wa.wave, pb3 ? w0a : a[6]);
			if (b[6] && m inside {3'h0, 3'h2} && a[5]) chk("fb", wb.wave, pb3 ? w0b : a[4]);
			pb3 = b[3];
			rd(TWC_OFS_CTRL_A, d);
			chk("rd_a", d, a & TWC_CTRL_A_MASK);
			rd(TWC_OFS_CTRL_B, d);
			chk("rd_b", d, b & TWC_CTRL_B_MASK);
		end
		rd(8'hB5, d);
		chk("unmapped", d, 8'h00);
		// clear-on-match, top 3: period is four counter ticks
		wr(TWC_OFS_CMP_A, 8'h03);
		wr(TWC_OFS_CTRL_A, 8'h42);
		for (int c = 1; c < 8; c++) begin
			wr(TWC_OFS_CTRL_B, 8'(c));
			repeat (3) gap(1'b0, n);
			chk("div_gap", 16'(n), 16'(4 * dv[c]));
		end
		wr(TWC_OFS_ASYNC, 8'h20);
		wr(TWC_OFS_CTRL_B, 8'h01);
		repeat (3) gap(1'b0, n);
		chk("xtal_gap", 16'(n), 16'd32);
		wr(TWC_OFS_ASYNC, 8'h00);
		foreach (mv[k]) begin
			wr(TWC_OFS_CTRL_A, {6'h00, mv[k][1:0]});
			wr(TWC_OFS_CTRL_B, {4'h0, mv[k][2], 3'h1});
			repeat (3) gap(1'b1, n);
			chk("ovf_gap", 16'(n), 16'(ev[k]));
		end
		// top 3, compare B 1, clear on match: high 2 of 4 (fast), 2 of 6 (phase)
		wr(TWC_OFS_CMP_B, 8'h01);
		wr(TWC_OFS_CTRL_A, 8'h23);
		repeat (16) @(posedge mclk);
		n = 0;
		repeat (8) begin
			@(posedge mclk);
			#1 n += int'(wb.wave);
		end
		chk("pwm_fast", 16'(n), 16'd4);
		wr(TWC_OFS_CTRL_A, 8'h21);
		repeat (16) @(posedge mclk);
		n = 0;
		repeat (12) begin
			@(posedge mclk);
			#1 n += int'(wb.wave);
		end
		chk("pwm_phase", 16'(n), 16'd4);
		print_verdict();
	end
endmodule
`default_nettype wire
